/* design/afc_spi_link.sv */
`timescale 1ns/1ns
// ==========================================
// serial port slave on the link clock
module afc_spi_link (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic [31:0] rd_bus_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	output logic wr_tgl_o,
	output logic [6:0] wr_addr_o,
	output logic [7:0] wr_data_o
);
	import afc_pkg::*;

	logic [3:0] cnt_r;
	logic [14:0] shift_r;
	logic rw_r;
	logic [7:0] rd_word_r;
	logic [31:0] rd_s1_r;
	logic [31:0] rd_s2_r;
	logic wr_tgl_r = 1'b0;
	logic [6:0] wr_addr_r = 7'h00;
	logic [7:0] wr_data_r = 8'h00;
	logic sdo_r;
	logic sdo_oe_r;
	logic [6:0] addr_now;
	logic [7:0] rd_sel;
	logic last_bit;

	// address as it completes on the eighth edge
	assign addr_now = {shift_r[5:0], sdi_i};
	assign last_bit = (cnt_r == 4'(FRAME_BITS - 1));
	// readback select, unmapped reads as zero
	assign rd_sel = afc_hit(addr_now, ADDR_MUX_CTRL) ? rd_s2_r[7:0] :
		afc_hit(addr_now, ADDR_IMPEDANCE) ? rd_s2_r[15:8] :
		afc_hit(addr_now, ADDR_TUNE_CTRL) ? rd_s2_r[23:16] :
		afc_hit(addr_now, ADDR_STATUS) ? rd_s2_r[31:24] : 8'h00;

	// mirror of the register file, quasi static between frames
	always_ff @(posedge sclk_i) begin
		rd_s1_r <= rd_bus_i;
		rd_s2_r <= rd_s1_r;
	end

	// bit counter and shifter, cleared by the frame signal
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cnt_r <= 4'h0;
			shift_r <= 15'h0000;
			rw_r <= 1'b0;
			rd_word_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			shift_r <= {shift_r[13:0], sdi_i};
			if (cnt_r == 4'h0) begin
				rw_r <= sdi_i;
			end
			if (cnt_r == 4'(ADDR_BITS - 1)) begin
				rd_word_r <= rd_sel;
			end
		end
	end

	// write word, handed over by a toggle
	always_ff @(posedge sclk_i) begin
		if (!cs_n_i && last_bit && !rw_r) begin
			wr_addr_r <= shift_r[13:7];
			wr_data_r <= {shift_r[6:0], sdi_i};
			wr_tgl_r <= ~wr_tgl_r;
		end
	end

	// read data shifts out on the falling edge
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sdo_r <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else begin
			sdo_oe_r <= rw_r && cnt_r >= 4'(ADDR_BITS);
			sdo_r <= rd_word_r[3'(4'(FRAME_BITS - 1) - cnt_r)];
		end
	end

	assign sdo_o = sdo_r;
	assign sdo_oe_o = sdo_oe_r;
	assign wr_tgl_o = wr_tgl_r;
	assign wr_addr_o = wr_addr_r;
	assign wr_data_o = wr_data_r;
endmodule : afc_spi_link

/* design/afc_top.sv */
`timescale 1ns/1ns
module afc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic aux_sel_i,
	input wire logic [1:0] mux_sel_i,
	input wire logic impedance_select_i,
	input wire logic gain_stage_over_i,
	input wire logic preamplifier_over_i,
	input wire logic tune_cmp_i,
	output logic aux_route_o,
	output logic [1:0] chan_sel_o,
	output logic chan_data_valid_o,
	output logic impedance_high_o,
	output logic tune_quarter_o,
	output logic [3:0] tune_scale_o,
	output logic [afc_pkg::TRIM_W-1:0] filter_trim_o,
	output logic tune_busy_o,
	output logic sat_flag_o
);
	import afc_pkg::*;

	// ==========================================
	// pin and link synchronisers
	logic [6:0] pin_s1_r;
	logic [6:0] pin_s2_r;
	logic [2:0] tgl_r;
	logic wr_tgl;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_stb;
	logic aux_pin;
	logic [1:0] mux_pin;
	logic imp_pin;
	logic over_any;
	logic cmp_s;

	// two flops before any logic reads a pin
	always_ff @(posedge clk_i) begin
		pin_s1_r <= {tune_cmp_i, preamplifier_over_i, gain_stage_over_i,
			impedance_select_i, mux_sel_i, aux_sel_i};
		pin_s2_r <= pin_s1_r;
	end

	// write toggle crossing, third flop finds the edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tgl_r <= 3'h0;
		end else begin
			tgl_r <= {tgl_r[1:0], wr_tgl};
		end
	end

	// synchronised pin views
	assign aux_pin = pin_s2_r[0];
	assign mux_pin = pin_s2_r[2:1];
	assign imp_pin = pin_s2_r[3];
	assign over_any = pin_s2_r[4] | pin_s2_r[5];
	assign cmp_s = pin_s2_r[6];
	assign wr_stb = tgl_r[1] ^ tgl_r[2];

	// ==========================================
	// register file
	logic [3:0] mux_ctrl_r;
	logic imp_r;
	logic quarter_r;
	logic [3:0] scale_r;
	logic wr_mux;
	logic wr_imp;
	logic wr_tune;
	logic [3:0] scale_in;
	logic spi_en;

	// write decode
	assign wr_mux = wr_stb & afc_hit(wr_addr, ADDR_MUX_CTRL);
	assign wr_imp = wr_stb & afc_hit(wr_addr, ADDR_IMPEDANCE);
	assign wr_tune = wr_stb & afc_hit(wr_addr, ADDR_TUNE_CTRL);
	// scale codes above 8 clamp to the top step
	assign scale_in = (wr_data[7:4] > SCALE_MAX) ? SCALE_MAX : wr_data[7:4];
	assign spi_en = mux_ctrl_r[MUX_SPI_EN_BIT];

	// configuration registers, pin control after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mux_ctrl_r <= MUX_CTRL_RST;
			imp_r <= IMP_RST;
			quarter_r <= QUARTER_RST;
			scale_r <= SCALE_RST;
		end else begin
			if (wr_mux) begin
				mux_ctrl_r <= wr_data[3:0];
			end
			if (wr_imp) begin
				imp_r <= wr_data[IMP_HIGH_BIT];
			end
			if (wr_tune) begin
				quarter_r <= wr_data[TUNE_QUARTER_BIT];
				scale_r <= scale_in;
			end
		end
	end

	// ==========================================
	// autotune engine
	afc_tune_st_t st_r;
	afc_tune_st_t st_nxt;
	logic [TRIM_W-1:0] trial_r;
	logic [TRIM_W-1:0] trial_nxt;
	logic [TRIM_W-1:0] hold_r;
	logic [TRIM_W-1:0] hold_nxt;
	logic [2:0] idx_r;
	logic [2:0] idx_nxt;
	logic [7:0] step_r;
	logic [7:0] step_nxt;
	logic busy_r;
	logic start;
	logic step_end;

	// requests while busy are ignored
	assign start = wr_tune & wr_data[TUNE_START_BIT] & (st_r == TU_IDLE);
	assign step_end = (step_r == 8'(TUNE_STEP_CYC - 1));

	// successive approximation, one trim bit per step
	always_comb begin
		st_nxt = st_r;
		trial_nxt = trial_r;
		hold_nxt = hold_r;
		idx_nxt = idx_r;
		step_nxt = step_r;
		case (st_r)
			TU_IDLE: begin
				if (start) begin
					st_nxt = TU_STEP;
					trial_nxt = TRIM_FIRST;
					idx_nxt = 3'(TRIM_W - 1);
					step_nxt = 8'h00;
				end
			end
			TU_STEP: begin
				step_nxt = step_r + 8'h01;
				if (step_end) begin
					trial_nxt[idx_r] = cmp_s;
					if (idx_r == 3'h0) begin
						st_nxt = TU_IDLE;
						hold_nxt = trial_nxt;
					end else begin
						idx_nxt = idx_r - 3'h1;
						trial_nxt[idx_nxt] = 1'b1;
					end
				end
			end
			default: begin
				st_nxt = TU_IDLE;
			end
		endcase
	end

	// engine state, trim starts at its highest cutoff
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= TU_IDLE;
			trial_r <= TRIM_MAX;
			hold_r <= TRIM_MAX;
			idx_r <= 3'h0;
			step_r <= 8'h00;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			trial_r <= trial_nxt;
			hold_r <= hold_nxt;
			idx_r <= idx_nxt;
			step_r <= step_nxt;
			busy_r <= (st_nxt == TU_STEP);
		end
	end

	// ==========================================
	// channel select and saturation hold
	logic aux_eff;
	logic [1:0] code_eff;
	logic [2:0] sat_cnt_r;

	// pins or serial register drive the mux
	assign aux_eff = spi_en ? mux_ctrl_r[MUX_AUX_BIT] : aux_pin;
	assign code_eff = spi_en ? mux_ctrl_r[1:0] : mux_pin;

	// hold counter reloads while the overvoltage lasts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sat_cnt_r <= 3'h0;
		end else if (over_any) begin
			sat_cnt_r <= 3'(SAT_HOLD_CYC);
		end else if (sat_cnt_r != 3'h0) begin
			sat_cnt_r <= sat_cnt_r - 3'h1;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_route_o <= 1'b0;
			chan_sel_o <= 2'h0;
			chan_data_valid_o <= 1'b0;
			impedance_high_o <= 1'b0;
			tune_quarter_o <= QUARTER_RST;
			tune_scale_o <= SCALE_RST;
			filter_trim_o <= TRIM_MAX;
			tune_busy_o <= 1'b0;
			sat_flag_o <= 1'b0;
		end else begin
			aux_route_o <= aux_eff;
			chan_sel_o <= code_eff;
			chan_data_valid_o <= aux_eff | ~busy_r;
			impedance_high_o <= imp_pin | imp_r;
			tune_quarter_o <= quarter_r;
			tune_scale_o <= scale_r;
			filter_trim_o <= (st_nxt == TU_STEP) ? trial_nxt : hold_nxt;
			tune_busy_o <= busy_r;
			sat_flag_o <= over_any | (sat_cnt_r != 3'h0);
		end
	end

	// ==========================================
	// serial port
	logic [31:0] rd_bus;

	// readback words: status, tune, impedance, mux
	assign rd_bus = {5'h00, chan_data_valid_o, sat_flag_o, busy_r,
		scale_r, 2'h0, quarter_r, 1'b0,
		7'h00, imp_r,
		4'h0, mux_ctrl_r};

	afc_spi_link u_link (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.sdi_i(sdi_i),
		.rd_bus_i(rd_bus),
		.sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o),
		.wr_tgl_o(wr_tgl),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data)
	);

	// ==========================================
	// checks
	logic [11:0] bcnt_r;

	// cycles spent busy
	always_ff @(posedge clk_i) begin
		if (rst_i || !busy_r) begin
			bcnt_r <= 12'h000;
		end else begin
			bcnt_r <= bcnt_r + 12'h001;
		end
	end

	chk_aux_route: assert property (@(posedge clk_i) disable iff (rst_i)
		(!spi_en && aux_pin) |=> aux_route_o)
		else $error("aux pin did not route aux input");
	chk_chan_code: assert property (@(posedge clk_i) disable iff (rst_i)
		(!spi_en && !aux_pin) |=> (chan_sel_o == $past(mux_pin) && !aux_route_o))
		else $error("channel code not followed");
	chk_pin_default: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !spi_en)
		else $error("serial mux control active after reset");
	chk_mux_source: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_en |=> (chan_sel_o == $past(mux_ctrl_r[1:0])))
		else $error("serial mux code ignored");
	chk_imp_force: assert property (@(posedge clk_i) disable iff (rst_i)
		imp_pin |=> impedance_high_o)
		else $error("impedance pin did not force high");
	chk_imp_serial: assert property (@(posedge clk_i) disable iff (rst_i)
		!imp_pin |=> (impedance_high_o == $past(imp_r)))
		else $error("serial impedance setting ignored");
	chk_tune_start: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy_r) |-> $past(start))
		else $error("tune began without request");
	chk_trim_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!busy_r && !start && !$past(busy_r)) |=> $stable(hold_r))
		else $error("trim changed outside a tune");
	chk_tune_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		bcnt_r < 12'(TUNE_MAX_CYC))
		else $error("tune ran past its bound");
	chk_trim_default: assert property (@(posedge clk_i)
		$fell(rst_i) |-> (hold_r == TRIM_MAX && filter_trim_o == TRIM_MAX))
		else $error("trim not at highest cutoff");
	chk_chan_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
		(busy_r && !aux_eff) |=> !chan_data_valid_o)
		else $error("channel valid during tune");
	chk_aux_usable: assert property (@(posedge clk_i) disable iff (rst_i)
		aux_eff |=> chan_data_valid_o)
		else $error("aux path blocked");
	chk_sat_set: assert property (@(posedge clk_i) disable iff (rst_i)
		over_any |=> sat_flag_o)
		else $error("saturation not flagged");
	chk_sat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(over_any) |-> sat_flag_o [*3])
		else $error("saturation hold too short");
	chk_busy_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		start |=> busy_r ##1 tune_busy_o)
		else $error("busy not raised on tune");
endmodule : afc_top

/* inc/afc_pkg.sv */
// ==========================================
// front end control constants
package afc_pkg;
	// register indices on the serial port
	localparam logic [6:0] ADDR_MUX_CTRL = 7'h0C;
	localparam logic [6:0] ADDR_IMPEDANCE = 7'h0D;
	localparam logic [6:0] ADDR_TUNE_CTRL = 7'h0E;
	localparam logic [6:0] ADDR_STATUS = 7'h0F;
	// field positions
	localparam int MUX_CODE_LSB = 0;
	localparam int MUX_AUX_BIT = 2;
	localparam int MUX_SPI_EN_BIT = 3;
	localparam int IMP_HIGH_BIT = 0;
	localparam int TUNE_START_BIT = 0;
	localparam int TUNE_QUARTER_BIT = 1;
	localparam int TUNE_SCALE_LSB = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SAT_BIT = 1;
	localparam int STAT_VALID_BIT = 2;
	// reset values
	localparam logic [3:0] MUX_CTRL_RST = 4'h0;
	localparam logic IMP_RST = 1'b0;
	localparam logic QUARTER_RST = 1'b0;
	localparam logic [3:0] SCALE_RST = 4'h4;
	localparam logic [3:0] SCALE_MAX = 4'h8;
	// serial frame: rw, 7 address bits, 8 data bits
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 8;
	// timing
	localparam int CLK_MHZ = 50;
	localparam int SAT_HOLD_NS = 25;
	localparam int SAT_HOLD_CYC = (SAT_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int TUNE_MAX_CYC = 2048;
	localparam int TUNE_STEP_CYC = 256;
	localparam int TRIM_W = 7;
	localparam logic [TRIM_W-1:0] TRIM_MAX = 7'h7F;
	localparam logic [TRIM_W-1:0] TRIM_FIRST = 7'h40;
	// autotune states
	typedef enum logic {TU_IDLE, TU_STEP} afc_tune_st_t;
	// address match
	function automatic logic afc_hit(input logic [6:0] a, input logic [6:0] r);
		afc_hit = (a == r);
	endfunction : afc_hit
endpackage : afc_pkg

/* test/afc_host_model.sv */
`timescale 1ns/1ns
// ==========================================
// serial host stand-in, link clock runs only inside frames
module afc_host_model (
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o
);
	// idle levels: select high, clock and data low
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		cs_n_o = 1'b0; // short select pulse clears the link counter at power-up
		#5;
		cs_n_o = 1'b1;
	end
	// one frame: rw, address, data, msb first, 30 ns link period
	task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] rd);
		logic [15:0] w;
		w = {rw, addr, data};
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			#15;
			if (i < 8) rd[i] = sdo_oe_i ? sdo_i : ~sdo_i; // undriven line reads inverted
			sclk_o = 1'b1;
			#15;
			sclk_o = 1'b0;
		end
		#15;
		cs_n_o = 1'b1;
		sdi_o = 1'b0; // released line sits at its pull-down level
		#120; // gap so the next frame never crowds a write crossing
	endtask : xfer
endmodule : afc_host_model

/* test/afc_top_tb.sv */
`timescale 1ns/1ns
// ==========================================
// bench for the front end control block
module afc_top_tb;
	import afc_pkg::*;
	`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
		$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
	typedef struct {int sel; logic [7:0] exp;} afc_note_t;
	logic clk_i, rst_i, sclk, cs_n, sdi, sdo, sdo_oe, aux, imp, gso, pso, cmp;
	logic aux_r, valid, imp_o, quart, busy, sat;
	logic [1:0] mux, chan;
	logic [3:0] scale;
	logic [6:0] trim;
	logic [7:0] rd;
	logic [15:0] rnd;
	int fails, comparisons, n;
	afc_note_t q[$];
	// ==========================================
	// device and host
	afc_top afc_top_i (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .aux_sel_i(aux), .mux_sel_i(mux), .impedance_select_i(imp), .gain_stage_over_i(gso),
		.preamplifier_over_i(pso), .tune_cmp_i(cmp), .aux_route_o(aux_r), .chan_sel_o(chan),
		.chan_data_valid_o(valid), .impedance_high_o(imp_o), .tune_quarter_o(quart), .tune_scale_o(scale),
		.filter_trim_o(trim), .tune_busy_o(busy), .sat_flag_o(sat));
	afc_host_model afc_host_model_i (.sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
	// 50 MHz sample clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		lfsr = {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
	endfunction : lfsr
	function automatic logic [7:0] obs(input int sel);
		case (sel)
			0: obs = {6'h00, chan};
			1: obs = {7'h00, aux_r};
			2: obs = {7'h00, imp_o};
			3: obs = {7'h00, quart};
			4: obs = {4'h0, scale};
			5: obs = {1'b0, trim};
			6: obs = {7'h00, busy};
			7: obs = {7'h00, valid};
			8: obs = {7'h00, sat};
			default: obs = rd;
		endcase
	endfunction : obs
	task automatic note(input int sel, input logic [7:0] exp);
		q.push_back('{sel, exp});
	endtask : note
	task automatic tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask : tick
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		rnd = lfsr(rnd);
		#(rnd[3:0]); // link phase wanders against the sample clock
		afc_host_model_i.xfer(1'b0, a, d, dummy);
		tick(6);
	endtask : wr
	task automatic rdr(input logic [6:0] a);
		rnd = lfsr(rnd);
		#(rnd[3:0]); // link phase wanders against the sample clock
		afc_host_model_i.xfer(1'b1, a, 8'h00, rd);
		tick(1);
	endtask : rdr
	task automatic wrap_up;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// monitor: oldest note first, against values settled before this edge
	always @(posedge clk_i) begin
		while (q.size() > 0) begin
			afc_note_t nt;
			nt = q.pop_front();
			`CHK(obs(nt.sel), nt.exp)
		end
	end
	// ==========================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		{aux, imp, gso, pso, cmp} = 5'h00;
		mux = 2'h0;
		rnd = 16'hD296;
		tick(20);
		rst_i = 1'b0;
		tick(1);
		note(4, 8'h04);
		note(5, 8'h7F);
		note(6, 8'h00);
		// pins steer the mux by default
		for (int i = 0; i < 8; i++) begin
			aux = i[2];
			mux = i[1:0];
			tick(4);
			note(1, {7'h00, i[2]});
			if (!i[2]) note(0, {6'h00, i[1:0]});
		end
		aux = 1'b0;
		mux = 2'h1;
		// serial register takes the mux, then hands it back
		wr(ADDR_MUX_CTRL, 8'h0A);
		note(0, 8'h02);
		wr(ADDR_MUX_CTRL, 8'h0E);
		note(1, 8'h01);
		wr(ADDR_MUX_CTRL, 8'h02);
		note(0, 8'h01);
		rdr(ADDR_MUX_CTRL);
		note(9, 8'h02);
		// impedance from register and pin
		wr(ADDR_IMPEDANCE, 8'h01);
		note(2, 8'h01);
		wr(ADDR_IMPEDANCE, 8'h00);
		note(2, 8'h00);
		imp = 1'b1;
		tick(4);
		note(2, 8'h01);
		imp = 1'b0;
		tick(4);
		note(2, 8'h00);
		// target settings without a start
		wr(ADDR_TUNE_CTRL, 8'h92);
		note(4, 8'h08);
		note(3, 8'h01);
		note(6, 8'h00);
		wr(ADDR_TUNE_CTRL, 8'h30);
		note(4, 8'h03);
		note(3, 8'h00);
		// two tunes, comparator held at each level once
		for (int t = 0; t < 2; t++) begin
			rnd = lfsr(rnd);
			cmp = (t == 0) ? rnd[0] : ~cmp; // second tune takes the other level
			wr(ADDR_TUNE_CTRL, 8'h41);
			note(6, 8'h01);
			note(7, 8'h00);
			wr(ADDR_TUNE_CTRL, 8'h41);
			aux = 1'b1;
			tick(4);
			note(1, 8'h01);
			note(7, 8'h01);
			aux = 1'b0;
			n = 0;
			while (busy === 1'b1 && n < TUNE_MAX_CYC) begin
				tick(1);
				n++;
			end
			if (n >= TUNE_MAX_CYC) begin
				fails++;
				wrap_up();
			end
			note(5, {1'b0, {7{cmp}}});
			note(6, 8'h00);
			note(7, 8'h01);
			tick(300);
			note(5, {1'b0, {7{cmp}}});
		end
		rdr(ADDR_STATUS);
		note(9, 8'h04);
		rdr(7'h20);
		note(9, 8'h00);
		// saturation from each detector, hold after release
		for (int j = 0; j < 2; j++) begin
			rnd = lfsr(rnd);
			gso = (j == 0);
			pso = (j == 1);
			tick(4);
			note(8, 8'h01);
			tick(rnd[2:0]);
			gso = 1'b0;
			pso = 1'b0;
			tick(4);
			note(8, 8'h01);
			tick(8);
			note(8, 8'h00);
		end
		tick(2);
		wrap_up();
	end
endmodule : afc_top_tb
